// ---- include/lms_pkg.sv ----
package lms_pkg;

  // Register offsets
  localparam logic [11:0] SKIP_COUNT_ADDR = 12'h036;
  localparam logic [11:0] JITTER_WINDOW_ADDR = 12'h039;
  localparam logic [11:0] SYNC_MODE_ADDR = 12'h03a;
  localparam logic [11:0] SYNC_CTRL_ADDR = 12'h03b;
  localparam logic [11:0] MF_DELAY_ADDR = 12'h304;
  localparam logic [11:0] RELEASE_DELAY_ADDR = 12'h306;
  localparam logic [11:0] SUBCLASS_ADDR = 12'h458;

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RAMP_BIT = 1;
  localparam int MODE_ARM_BIT = 1;
  localparam int MODE_DONE_BIT = 4;
  localparam int SUBCLASS_LSB = 5;
  localparam int WINDOW_MSB = 5;

  // Reset values and field codes
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] SUBCLASS_ONE = 3'h1;

  // Timing and lane width
  localparam int FRAMES_PER_MF = 32;
  localparam int OCTETS_PER_PCLK = 4;
  localparam int MAX_RELEASE_DELAY = 12;
  localparam int LANE_DATA_W = 8 * OCTETS_PER_PCLK;

  typedef enum {
    SYNC_IDLE,
    SYNC_ARMED,
    SYNC_RUN
  } lms_state_type;

  typedef struct packed {
    logic valid;
    logic [LANE_DATA_W-1:0] data;
  } lms_beat_type;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [11:0] addr;
    logic [7:0] wrData;
  } lms_regreq_type;

endpackage

// ---- src/lms_sync.sv ----
`timescale 1ns/1ps
module lms_sync #(
  parameter int OCTETS_PER_FRAME = 1,
  parameter int DAC_PER_PCLK = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire lms_pkg::lms_regreq_type regReq,
  output logic [7:0] regRdData,
  // Alignment reference, sampled
  input wire logic alignRef,
  // Lane data
  input wire lms_pkg::lms_beat_type laneIn,
  output lms_pkg::lms_beat_type laneOut,
  // Link status
  output logic linkSyncOut,
  output logic localMfClock,
  output logic rampActive,
  output logic alignmentJitterInterrupt
);

  localparam int MF_CYCLES = lms_pkg::FRAMES_PER_MF * OCTETS_PER_FRAME
    / lms_pkg::OCTETS_PER_PCLK;
  localparam int DEPTH = lms_pkg::MAX_RELEASE_DELAY + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] skipCount_q, skipCount_d;
  logic [7:0] jitterWin_q, jitterWin_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] mfDelay_q, mfDelay_d;
  logic [7:0] relDelay_q, relDelay_d;
  logic [7:0] subclassCfg_q, subclassCfg_d;
  logic arm_q, arm_d;
  logic done_q, done_d;
  logic [7:0] rdData_q, rdData_d;
  logic armRise;
  logic subclassOne;

  assign armRise = regReq.wrEn && regReq.addr == lms_pkg::SYNC_MODE_ADDR
    && regReq.wrData[lms_pkg::MODE_ARM_BIT] && !arm_q;
  assign subclassOne = subclassCfg_q[7:lms_pkg::SUBCLASS_LSB] == lms_pkg::SUBCLASS_ONE;

  ////////////////////////////////////////////////////////////////////////////
  // Sync state
  lms_pkg::lms_state_type state_q, state_d;
  logic [7:0] skipLeft_q, skipLeft_d;
  logic [7:0] mfCnt_q, mfCnt_d;
  logic refPrev_q, refPrev_d;
  logic jitter_q, jitter_d;
  logic linkSync_q, linkSync_d;
  logic localMf_q, localMf_d;
  logic ramp_q, ramp_d;
  logic refRise;
  logic alignEdge;
  logic alignNow;
  logic [7:0] mfDist;
  logic [15:0] devDac;

  assign refRise = alignRef && !refPrev_q;
  assign alignEdge = subclassOne ? refRise : 1'b1;
  assign alignNow = state_q == lms_pkg::SYNC_ARMED && alignEdge
    && (!subclassOne || skipLeft_q == 8'h00);
  assign mfDist = (mfCnt_q < 8'(MF_CYCLES / 2)) ? mfCnt_q : 8'(MF_CYCLES) - mfCnt_q;
  assign devDac = 16'(mfDist) * 16'(DAC_PER_PCLK);

  always_comb begin
    skipCount_d = skipCount_q;
    jitterWin_d = jitterWin_q;
    ctrl_d = ctrl_q;
    mfDelay_d = mfDelay_q;
    relDelay_d = relDelay_q;
    subclassCfg_d = subclassCfg_q;
    arm_d = arm_q;
    rdData_d = 8'h00;
    if (regReq.wrEn) begin
      unique case (regReq.addr)
        lms_pkg::SKIP_COUNT_ADDR: skipCount_d = regReq.wrData;
        lms_pkg::JITTER_WINDOW_ADDR: jitterWin_d = regReq.wrData;
        lms_pkg::SYNC_MODE_ADDR: arm_d = regReq.wrData[lms_pkg::MODE_ARM_BIT];
        lms_pkg::SYNC_CTRL_ADDR: ctrl_d = regReq.wrData;
        lms_pkg::MF_DELAY_ADDR: mfDelay_d = regReq.wrData;
        lms_pkg::RELEASE_DELAY_ADDR: relDelay_d = regReq.wrData;
        lms_pkg::SUBCLASS_ADDR: subclassCfg_d = regReq.wrData;
        default: ;
      endcase
    end
    if (regReq.rdEn) begin
      unique case (regReq.addr)
        lms_pkg::SKIP_COUNT_ADDR: rdData_d = skipCount_q;
        lms_pkg::JITTER_WINDOW_ADDR: rdData_d = jitterWin_q;
        lms_pkg::SYNC_MODE_ADDR: begin
          rdData_d[lms_pkg::MODE_ARM_BIT] = arm_q;
          rdData_d[lms_pkg::MODE_DONE_BIT] = done_q;
        end
        lms_pkg::SYNC_CTRL_ADDR: rdData_d = ctrl_q;
        lms_pkg::MF_DELAY_ADDR: rdData_d = mfDelay_q;
        lms_pkg::RELEASE_DELAY_ADDR: rdData_d = relDelay_q;
        lms_pkg::SUBCLASS_ADDR: rdData_d = subclassCfg_q;
        default: rdData_d = 8'h00;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    skipLeft_d = skipLeft_q;
    done_d = done_q;
    jitter_d = jitter_q;
    linkSync_d = linkSync_q;
    refPrev_d = alignRef;
    mfCnt_d = (mfCnt_q == 8'(MF_CYCLES - 1)) ? 8'h00 : mfCnt_q + 8'h01;
    localMf_d = mfCnt_q == mfDelay_q;
    ramp_d = ctrl_q[lms_pkg::CTRL_RAMP_BIT] && state_q == lms_pkg::SYNC_ARMED;
    unique case (state_q)
      lms_pkg::SYNC_IDLE, lms_pkg::SYNC_RUN: begin
        if (armRise && ctrl_q[lms_pkg::CTRL_ENABLE_BIT]) begin
          state_d = lms_pkg::SYNC_ARMED;
          skipLeft_d = skipCount_q;
          done_d = 1'b0;
          jitter_d = 1'b0;
          linkSync_d = 1'b0;
        end
        // Jitter event wins over a clear in the same cycle
        if (state_q == lms_pkg::SYNC_RUN && subclassOne && refRise
            && devDac > 16'(jitterWin_q[lms_pkg::WINDOW_MSB:0])) begin
          jitter_d = 1'b1;
        end
      end
      lms_pkg::SYNC_ARMED: begin
        if (alignNow) begin
          state_d = lms_pkg::SYNC_RUN;
          mfCnt_d = 8'h01;
          done_d = 1'b1;
          linkSync_d = 1'b1;
        end else if (alignEdge && subclassOne) begin
          skipLeft_d = skipLeft_q - 8'h01;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer delay
  lms_pkg::lms_beat_type pipe_q [DEPTH];
  lms_pkg::lms_beat_type pipe_d [DEPTH];
  lms_pkg::lms_beat_type laneOut_d, laneOut_q;
  logic [3:0] tap;

  assign tap = (relDelay_q > 8'(lms_pkg::MAX_RELEASE_DELAY))
    ? 4'(lms_pkg::MAX_RELEASE_DELAY) : relDelay_q[3:0];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_pipe
      if (gi == 0) begin : g_head
        assign pipe_d[gi] = laneIn;
      end else begin : g_tail
        assign pipe_d[gi] = pipe_q[gi-1];
      end
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          pipe_q[gi] <= '0;
        end else begin
          pipe_q[gi] <= pipe_d[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    laneOut_d = pipe_d[tap];
    laneOut_d.valid = pipe_d[tap].valid && linkSync_q;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      skipCount_q <= lms_pkg::REG_RESET;
      jitterWin_q <= lms_pkg::REG_RESET;
      ctrl_q <= lms_pkg::REG_RESET;
      mfDelay_q <= lms_pkg::REG_RESET;
      relDelay_q <= lms_pkg::REG_RESET;
      subclassCfg_q <= lms_pkg::REG_RESET;
      arm_q <= 1'b0;
      done_q <= 1'b0;
      rdData_q <= 8'h00;
      state_q <= lms_pkg::SYNC_IDLE;
      skipLeft_q <= 8'h00;
      mfCnt_q <= 8'h00;
      refPrev_q <= 1'b0;
      jitter_q <= 1'b0;
      linkSync_q <= 1'b0;
      localMf_q <= 1'b0;
      ramp_q <= 1'b0;
      laneOut_q <= '0;
    end else begin
      skipCount_q <= skipCount_d;
      jitterWin_q <= jitterWin_d;
      ctrl_q <= ctrl_d;
      mfDelay_q <= mfDelay_d;
      relDelay_q <= relDelay_d;
      subclassCfg_q <= subclassCfg_d;
      arm_q <= arm_d;
      done_q <= done_d;
      rdData_q <= rdData_d;
      state_q <= state_d;
      skipLeft_q <= skipLeft_d;
      mfCnt_q <= mfCnt_d;
      refPrev_q <= refPrev_d;
      jitter_q <= jitter_d;
      linkSync_q <= linkSync_d;
      localMf_q <= localMf_d;
      ramp_q <= ramp_d;
      laneOut_q <= laneOut_d;
    end
  end

  assign regRdData = rdData_q;
  assign laneOut = laneOut_q;
  assign linkSyncOut = linkSync_q;
  assign localMfClock = localMf_q;
  assign rampActive = ramp_q;
  assign alignmentJitterInterrupt = jitter_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence armSeq;
    armRise && ctrl_q[lms_pkg::CTRL_ENABLE_BIT] && state_q != lms_pkg::SYNC_ARMED;
  endsequence

  sequence alignSeq;
    alignNow;
  endsequence

  link_drop_a: assert property (armSeq |=> !linkSyncOut && !done_q)
    else $error("link sync not dropped on arm");
  link_return_a: assert property (alignSeq |=> linkSyncOut && done_q)
    else $error("link sync not restored after rotation");
  done_hold_a: assert property (done_q && !armRise |=> done_q)
    else $error("done flag lost without re-arm");
  done_read_a: assert property (regReq.rdEn && regReq.addr == lms_pkg::SYNC_MODE_ADDR
    |=> regRdData[lms_pkg::MODE_DONE_BIT] == $past(done_q))
    else $error("done flag readback wrong");
  skip_ignore_a: assert property (state_q == lms_pkg::SYNC_ARMED && subclassOne
    && skipLeft_q != 8'h00 |-> !alignNow)
    else $error("aligned before skip count");
  sub0_align_a: assert property (state_q == lms_pkg::SYNC_ARMED && !subclassOne
    |=> state_q == lms_pkg::SYNC_RUN)
    else $error("subclass 0 did not align on internal edge");
  ctrl_gate_a: assert property (armRise && !ctrl_q[lms_pkg::CTRL_ENABLE_BIT]
    && state_q != lms_pkg::SYNC_ARMED |=> state_q != lms_pkg::SYNC_ARMED)
    else $error("armed while sync disabled");
  lane_invalid_a: assert property (!linkSync_q |=> !laneOut.valid)
    else $error("lane data valid while link down");
  mf_delay_a: assert property (state_q == lms_pkg::SYNC_RUN && mfCnt_q == mfDelay_q
    |=> localMfClock)
    else $error("local multiframe clock misplaced");
  buffer_delay_a: assert property (relDelay_q == 8'h00 && $stable(relDelay_q)
    && linkSync_q |=> laneOut.data == $past(laneIn.data))
    else $error("zero release delay not applied");

endmodule

// ---- verif/lms_far_model.sv ----
`timescale 1ns/1ps
module lms_far_model (
  // Clock
  input wire logic ref_clk,
  // Far side outputs
  output logic alignRef,
  output lms_pkg::lms_beat_type laneIn
);
  logic [31:0] beatCount_q = 32'h0;
  initial alignRef = 1'b0;
  // One four-octet beat per cycle, counting
  always @(negedge ref_clk) begin
    beatCount_q <= beatCount_q + 32'h1;
  end
  assign laneIn = {1'b1, beatCount_q};
  // Reference pulse, two cycles wide
  task automatic refPulse();
    @(negedge ref_clk);
    alignRef = 1'b1;
    repeat (2) @(negedge ref_clk);
    alignRef = 1'b0;
  endtask
endmodule

// ---- verif/lms_sync_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module lms_sync_tb;
  logic ref_clk;
  logic reset;
  lms_pkg::lms_regreq_type regReq;
  logic [7:0] regRdData;
  logic alignRef;
  lms_pkg::lms_beat_type laneIn;
  lms_pkg::lms_beat_type laneOut;
  logic linkSyncOut;
  logic localMfClock;
  logic rampActive;
  logic alignmentJitterInterrupt;
  int failures = 0;
  int checks = 0;
  logic [7:0] rd;
  int off0;
  int off3;
  lms_sync #(.OCTETS_PER_FRAME(1), .DAC_PER_PCLK(16)) uut (.ref_clk(ref_clk), .reset(reset),
    .regReq(regReq), .regRdData(regRdData), .alignRef(alignRef), .laneIn(laneIn),
    .laneOut(laneOut), .linkSyncOut(linkSyncOut), .localMfClock(localMfClock),
    .rampActive(rampActive), .alignmentJitterInterrupt(alignmentJitterInterrupt));
  lms_far_model far (.ref_clk(ref_clk), .alignRef(alignRef), .laneIn(laneIn));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic waitN(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic regWrite(input logic [11:0] addr, input logic [7:0] data);
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: addr, wrData: data};
    @(negedge ref_clk);
    regReq = '0;
    @(negedge ref_clk);
  endtask
  task automatic regRead(input logic [11:0] addr, output logic [7:0] val);
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: addr, wrData: 8'h00};
    @(negedge ref_clk);
    val = regRdData;
    regReq = '0;
    @(negedge ref_clk);
  endtask
  task automatic arm();
    regWrite(lms_pkg::SYNC_MODE_ADDR, 8'h00);
    regWrite(lms_pkg::SYNC_MODE_ADDR, 8'h02);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic resetScenario();
    logic [11:0] addrs [7] = '{12'h036, 12'h039, 12'h03a, 12'h03b, 12'h304, 12'h306,
      12'h458};
    foreach (addrs[i]) begin
      regRead(addrs[i], rd);
      `CHK(rd, 8'h00)
    end
    regRead(12'h100, rd);
    `CHK(rd, 8'h00)
    `CHK(linkSyncOut, 1'b0)
  endtask
  task automatic ctrlScenario();
    arm();
    waitN(3);
    `CHK(linkSyncOut, 1'b0)
    regWrite(lms_pkg::SYNC_CTRL_ADDR, 8'hf1);
    regRead(lms_pkg::SYNC_CTRL_ADDR, rd);
    `CHK(rd, 8'hf1)
  endtask
  task automatic sub0Scenario();
    arm();
    `CHK(linkSyncOut, 1'b1)
    waitN(1);
    `CHK(linkSyncOut, 1'b1)
    regRead(lms_pkg::SYNC_MODE_ADDR, rd);
    `CHK(rd, 8'h12)
    regWrite(lms_pkg::SYNC_MODE_ADDR, 8'h02);
    waitN(2);
    `CHK(linkSyncOut, 1'b1)
    regRead(lms_pkg::SYNC_MODE_ADDR, rd);
    `CHK(rd, 8'h12)
    regWrite(lms_pkg::SYNC_MODE_ADDR, 8'h00);
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: lms_pkg::SYNC_MODE_ADDR, wrData: 8'h02};
    @(negedge ref_clk);
    `CHK(linkSyncOut, 1'b0)
    regReq = '0;
    @(negedge ref_clk);
    `CHK(linkSyncOut, 1'b1)
    `CHK(rampActive, 1'b0)
  endtask
  task automatic mfOffset(input logic [7:0] d, output int off);
    regWrite(lms_pkg::MF_DELAY_ADDR, d);
    arm();
    off = 1;
    waitN(1);
    while (localMfClock !== 1'b1 && off < 20) begin
      waitN(1);
      off++;
    end
  endtask
  task automatic mfScenario();
    int per;
    mfOffset(8'h00, off0);
    mfOffset(8'h03, off3);
    `CHK(((off3 - off0) + 8) % 8, 3)
    per = 1;
    waitN(1);
    while (localMfClock !== 1'b1 && per < 20) begin
      waitN(1);
      per++;
    end
    `CHK(per, 8)
  endtask
  task automatic laneScenario();
    regWrite(lms_pkg::RELEASE_DELAY_ADDR, 8'h03);
    waitN(16);
    `CHK(laneOut, {1'b1, far.beatCount_q - 32'd3})
    regWrite(lms_pkg::RELEASE_DELAY_ADDR, 8'h08);
    waitN(16);
    `CHK(laneOut, {1'b1, far.beatCount_q - 32'd8})
  endtask
  task automatic sub1Scenario();
    regWrite(lms_pkg::SYNC_CTRL_ADDR, 8'hf3);
    regWrite(lms_pkg::SUBCLASS_ADDR, 8'h20);
    regWrite(lms_pkg::JITTER_WINDOW_ADDR, 8'h00);
    regWrite(lms_pkg::SKIP_COUNT_ADDR, 8'h02);
    arm();
    waitN(4);
    `CHK(rampActive, 1'b1)
    `CHK(laneOut.valid, 1'b0)
    far.refPulse();
    far.refPulse();
    waitN(4);
    `CHK(linkSyncOut, 1'b0)
    far.refPulse();
    waitN(1);
    `CHK(linkSyncOut, 1'b1)
    waitN(3);
    far.refPulse();
    waitN(2);
    `CHK(alignmentJitterInterrupt, 1'b1)
    regWrite(lms_pkg::SKIP_COUNT_ADDR, 8'h00);
    arm();
    `CHK(alignmentJitterInterrupt, 1'b0)
    `CHK(linkSyncOut, 1'b0)
    far.refPulse();
    waitN(1);
    `CHK(linkSyncOut, 1'b1)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    failures++;
    summarize();
  end
  initial begin
    regReq = '0;
    reset = 1'b1;
    waitN(10);
    reset = 1'b0;
    waitN(1);
    resetScenario();
    ctrlScenario();
    sub0Scenario();
    mfScenario();
    laneScenario();
    sub1Scenario();
    summarize();
  end
endmodule
